// File: design/pllcw_consts.vh
`ifndef PLLCW_CONSTS_VH
`define PLLCW_CONSTS_VH
// Serial word layout
`define PLLCW_WORD_W        32
`define PLLCW_CNT_W         6
`define PLLCW_SEL_LO_BIT    0
`define PLLCW_SEL_HI_BIT    1
`define PLLCW_SEL_CODE      2'h2
`define PLLCW_POL_BIT       2
`define PLLCW_PRESET_BIT    3
`define PLLCW_CUR_LSB       4
`define PLLCW_CUR_W         4
`define PLLCW_PFD_LSB       8
`define PLLCW_PFD_W         2
`define PLLCW_FB_LSB        10
`define PLLCW_MUX_W         3
`define PLLCW_OUT0_LSB      13
`define PLLCW_OUT_NUM       5
`define PLLCW_POWER_BIT     28
`define PLLCW_SHARED_BIT    29
`define PLLCW_DIVRUN_BIT    30
`define PLLCW_PUMPON_BIT    31
// Power-up value of the whole word
`define PLLCW_RESET_VALUE   32'hDB6D_B4A2
`endif

// File: design/pllcw_shifter.v
`timescale 1ns/1ps
`include "pllcw_consts.vh"
// Serial shift register: MSB first, word complete on rising latch enable
module pllcw_shifter (
  input  wire        clk,
  input  wire        rst,
  input  wire        ser_clk_rise,
  input  wire        ser_data,
  input  wire        ser_latch_rise,
  output reg  [31:0] word,
  output reg         word_valid
);
  always @(posedge clk) begin
    if (rst) begin
      word       <= 32'h0000_0000;
      word_valid <= 1'b0;
    end else begin
      word_valid <= ser_latch_rise;
      if (ser_clk_rise) begin
        word <= {word[30:0], ser_data};
      end
    end
  end
endmodule

// File: design/pllcw_edge.v
`timescale 1ns/1ps
// Registers a synchronous pin and flags its rising edge
module pllcw_edge (
  input  wire clk,
  input  wire rst,
  input  wire pin,
  output reg  rise
);
  reg prev;
  always @(posedge clk) begin
    if (rst) begin
      prev <= 1'b0;
      rise <= 1'b0;
    end else begin
      prev <= pin;
      rise <= pin & ~prev;
    end
  end
endmodule

// File: design/pllcw_top.v
// Operation
// - Bit 2 sets pump polarity, 0 positive and 1 negative current when reference leads.
// - Bit 3 at 1 presets the pump output to half its supply, powering up at 0.
// - Bits 4 to 7 hold the pump current setting with bit 4 least significant.
// - Bits 8 and 9 hold the phase detector pulse width, bit 8 least, powering up at 0.
// - Bits 10 to 12 hold the feedback select, powering up to binary 101.
// - Five three-bit output source selects sit at bits 13 to 27, each powering up to 101.
// - Bit 28 at 0 powers the device down, at 1 it runs, powering up at 1.
// - Bit 29 makes the shared pin a divider reset at 0 or a pump hold at 1.
// - Bit 30 at 0 holds all dividers in reset like the reset pin, powering up at 1.
// - Bit 31 at 0 puts the pump output in high impedance like the hold pin.
`timescale 1ns/1ps
`include "pllcw_consts.vh"
module pllcw_top (
  input  wire        clk,
  input  wire        rst,
  input  wire        ser_clk,
  input  wire        ser_data,
  input  wire        ser_latch,
  input  wire        shared_pin,
  output reg  [31:0] pll_control_word_two,
  output reg         pump_polarity,
  output reg         pump_midrail_preset,
  output reg  [3:0]  pump_current,
  output reg  [1:0]  phase_detector_width,
  output reg  [2:0]  feedback_select,
  output reg  [14:0] out_source,
  output reg         power_down_n,
  output reg         shared_pin_function,
  output reg         divider_reset,
  output reg         pump_hold
);
  // Power-up value of each field, sliced from the word
  localparam [31:0] RESET_WORD    = `PLLCW_RESET_VALUE;
  localparam [0:0]  RST_POLARITY  = RESET_WORD[`PLLCW_POL_BIT];
  localparam [0:0]  RST_PRESET    = RESET_WORD[`PLLCW_PRESET_BIT];
  localparam [3:0]  RST_CURRENT   = RESET_WORD[`PLLCW_CUR_LSB +: `PLLCW_CUR_W];
  localparam [1:0]  RST_DET_WIDTH = RESET_WORD[`PLLCW_PFD_LSB +: `PLLCW_PFD_W];
  localparam [2:0]  RST_FB_SEL    = RESET_WORD[`PLLCW_FB_LSB +: `PLLCW_MUX_W];
  localparam [14:0] RST_OUT_SRC   = RESET_WORD[`PLLCW_OUT0_LSB +: `PLLCW_OUT_NUM * `PLLCW_MUX_W];
  localparam [0:0]  RST_POWER_N   = RESET_WORD[`PLLCW_POWER_BIT];
  localparam [0:0]  RST_SHARED_FN = RESET_WORD[`PLLCW_SHARED_BIT];
  localparam [0:0]  RST_DIV_RESET = ~RESET_WORD[`PLLCW_DIVRUN_BIT];
  localparam [0:0]  RST_PUMP_HOLD = ~RESET_WORD[`PLLCW_PUMPON_BIT];

  wire        clk_rise;
  wire        latch_rise;
  wire [31:0] shift_word;
  wire        shift_valid;
  wire        load_code_ok;
  wire        load_word;
  reg  [31:0] next_word;

  // Fields of the incoming word and their next values
  wire        shift_pump_polarity;
  wire        shift_pump_midrail_preset;
  wire [3:0]  shift_pump_current;
  wire [1:0]  shift_phase_detector_width;
  wire [2:0]  shift_feedback_select;
  wire [14:0] shift_out_source;
  wire        shift_power_down_n;
  wire        shift_shared_pin_function;
  reg         next_pump_polarity;
  reg         next_pump_midrail_preset;
  reg  [3:0]  next_pump_current;
  reg  [1:0]  next_phase_detector_width;
  reg  [2:0]  next_feedback_select;
  reg  [14:0] next_out_source;
  reg         next_power_down_n;
  reg         next_shared_pin_function;

  // Shared pin and register conditions
  wire        dividers_run;
  wire        pump_active;
  reg         pin_divider_reset;
  reg         pin_pump_hold;
  wire        next_divider_reset;
  wire        next_pump_hold;

  pllcw_edge u_clk_edge (
    .clk  (clk),
    .rst  (rst),
    .pin  (ser_clk),
    .rise (clk_rise)
  );

  pllcw_edge u_latch_edge (
    .clk  (clk),
    .rst  (rst),
    .pin  (ser_latch),
    .rise (latch_rise)
  );

  pllcw_shifter u_shift (
    .clk            (clk),
    .rst            (rst),
    .ser_clk_rise   (clk_rise),
    .ser_data       (ser_data),
    .ser_latch_rise (latch_rise),
    .word           (shift_word),
    .word_valid     (shift_valid)
  );

  // Serial word is accepted only with the select pattern in its low bits
  assign load_code_ok = (shift_word[`PLLCW_SEL_HI_BIT:`PLLCW_SEL_LO_BIT] ==
                         `PLLCW_SEL_CODE);
  assign load_word    = shift_valid & load_code_ok;

  always @* begin
    next_word = pll_control_word_two;
    if (load_word) begin
      next_word = shift_word;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      pll_control_word_two <= RESET_WORD;
    end else begin
      pll_control_word_two <= next_word;
    end
  end

  // Field slices of the incoming word
  assign shift_pump_polarity        = shift_word[`PLLCW_POL_BIT];
  assign shift_pump_midrail_preset  = shift_word[`PLLCW_PRESET_BIT];
  assign shift_pump_current         = shift_word[`PLLCW_CUR_LSB +: `PLLCW_CUR_W];
  assign shift_phase_detector_width = shift_word[`PLLCW_PFD_LSB +: `PLLCW_PFD_W];
  assign shift_feedback_select      = shift_word[`PLLCW_FB_LSB +: `PLLCW_MUX_W];
  assign shift_power_down_n         = shift_word[`PLLCW_POWER_BIT];
  assign shift_shared_pin_function  = shift_word[`PLLCW_SHARED_BIT];

  // One select field per output pair
  genvar g;
  generate
    for (g = 0; g < `PLLCW_OUT_NUM; g = g + 1) begin : g_out
      assign shift_out_source[g*`PLLCW_MUX_W +: `PLLCW_MUX_W] =
               shift_word[`PLLCW_OUT0_LSB + g*`PLLCW_MUX_W +: `PLLCW_MUX_W];
    end
  endgenerate

  // Fields hold until an accepted word replaces them
  always @* begin
    next_pump_polarity = pump_polarity;
    if (load_word) begin
      next_pump_polarity = shift_pump_polarity;
    end
  end

  always @* begin
    next_pump_midrail_preset = pump_midrail_preset;
    if (load_word) begin
      next_pump_midrail_preset = shift_pump_midrail_preset;
    end
  end

  always @* begin
    next_pump_current = pump_current;
    if (load_word) begin
      next_pump_current = shift_pump_current;
    end
  end

  always @* begin
    next_phase_detector_width = phase_detector_width;
    if (load_word) begin
      next_phase_detector_width = shift_phase_detector_width;
    end
  end

  always @* begin
    next_feedback_select = feedback_select;
    if (load_word) begin
      next_feedback_select = shift_feedback_select;
    end
  end

  always @* begin
    next_out_source = out_source;
    if (load_word) begin
      next_out_source = shift_out_source;
    end
  end

  always @* begin
    next_power_down_n = power_down_n;
    if (load_word) begin
      next_power_down_n = shift_power_down_n;
    end
  end

  always @* begin
    next_shared_pin_function = shared_pin_function;
    if (load_word) begin
      next_shared_pin_function = shift_shared_pin_function;
    end
  end

  // Pin function decode and the combined hold conditions
  assign dividers_run = next_word[`PLLCW_DIVRUN_BIT];
  assign pump_active  = next_word[`PLLCW_PUMPON_BIT];

  always @* begin
    pin_divider_reset = 1'b0;
    pin_pump_hold     = 1'b0;
    case (next_shared_pin_function)
      1'b0: begin
        pin_divider_reset = shared_pin;
      end
      1'b1: begin
        pin_pump_hold = shared_pin;
      end
      default: begin
        pin_divider_reset = 1'b0;
        pin_pump_hold     = 1'b0;
      end
    endcase
  end

  assign next_divider_reset = ~dividers_run | pin_divider_reset;
  assign next_pump_hold     = ~pump_active | pin_pump_hold;

  // Registered outputs
  always @(posedge clk) begin
    if (rst) begin
      pump_polarity <= RST_POLARITY;
    end else begin
      pump_polarity <= next_pump_polarity;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      pump_midrail_preset <= RST_PRESET;
    end else begin
      pump_midrail_preset <= next_pump_midrail_preset;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      pump_current <= RST_CURRENT;
    end else begin
      pump_current <= next_pump_current;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      phase_detector_width <= RST_DET_WIDTH;
    end else begin
      phase_detector_width <= next_phase_detector_width;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      feedback_select <= RST_FB_SEL;
    end else begin
      feedback_select <= next_feedback_select;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      out_source <= RST_OUT_SRC;
    end else begin
      out_source <= next_out_source;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      power_down_n <= RST_POWER_N;
    end else begin
      power_down_n <= next_power_down_n;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      shared_pin_function <= RST_SHARED_FN;
    end else begin
      shared_pin_function <= next_shared_pin_function;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      divider_reset <= RST_DIV_RESET;
    end else begin
      divider_reset <= next_divider_reset;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      pump_hold <= RST_PUMP_HOLD;
    end else begin
      pump_hold <= next_pump_hold;
    end
  end
endmodule

// File: test/pllcw_monitor.sv
`timescale 1ns/1ps
module pllcw_monitor (
  input logic        clk,
  input logic        rst,
  input logic        shared_pin,
  input logic [31:0] pll_control_word_two,
  input logic        pump_polarity,
  input logic        pump_midrail_preset,
  input logic [3:0]  pump_current,
  input logic [1:0]  phase_detector_width,
  input logic [2:0]  feedback_select,
  input logic [14:0] out_source,
  input logic        power_down_n,
  input logic        shared_pin_function,
  input logic        divider_reset,
  input logic        pump_hold
);
  wire [31:0] w = pll_control_word_two;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_low_fields: assert property (
    {phase_detector_width, pump_current, pump_midrail_preset, pump_polarity} == w[9:2])
    else $error("low fields");
  chk_fb_field: assert property (feedback_select == w[12:10])
    else $error("feedback");
  chk_out_field: assert property (out_source == w[27:13])
    else $error("out source");
  chk_pd_field: assert property (power_down_n == w[28])
    else $error("power down");
  chk_shared_fn: assert property (shared_pin_function == w[29])
    else $error("shared fn");
  chk_div_reset: assert property (
    ($stable(w) && $stable(shared_pin))[*2] |-> divider_reset == (!w[30] || !w[29] && shared_pin))
    else $error("div reset");
  chk_pump_hold: assert property (
    ($stable(w) && $stable(shared_pin))[*2] |-> pump_hold == (!w[31] || w[29] && shared_pin))
    else $error("pump hold");
  chk_load_code: assert property (!$stable(w) |-> w[1:0] == 2'b10)
    else $error("load code");
  chk_reset_word: assert property ($past(rst) |-> w == 32'hDB6D_B4A2)
    else $error("reset word");
endmodule

// File: test/pllcw_top_test.sv
`timescale 1ns/1ps
module pllcw_top_test;
  logic        clk = 0, rst = 1, ser_clk = 0, ser_data = 0, ser_latch = 0, shared_pin = 0;
  logic [31:0] e = 32'hDB6D_B4A2, v;
  wire  [31:0] word;
  wire  [27:0] fld;
  wire         dr, ph;
  int          num_errors = 0, samples_checked = 0;
  pllcw_top u_dut (.clk(clk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_latch(ser_latch), .shared_pin(shared_pin), .pll_control_word_two(word),
    .pump_polarity(fld[0]), .pump_midrail_preset(fld[1]), .pump_current(fld[5:2]),
    .phase_detector_width(fld[7:6]), .feedback_select(fld[10:8]), .out_source(fld[25:11]),
    .power_down_n(fld[26]), .shared_pin_function(fld[27]), .divider_reset(dr), .pump_hold(ph));
  always #50 clk = ~clk;
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(string n, logic [31:0] x, logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  function automatic logic exp_div(logic [31:0] w, logic p);
    return !w[30] || (!w[29] && p);
  endfunction
  function automatic logic exp_hold(logic [31:0] w, logic p);
    return !w[31] || (w[29] && p);
  endfunction
  task automatic send(logic [31:0] d);
    shared_pin = 1'($urandom_range(1));
    for (int i = 31; i >= 0; i--) begin
      ser_data = d[i];
      ser_clk = 1;
      tick(2);
      ser_clk = 0;
      tick(2);
    end
    ser_latch = 1;
    tick(2);
    ser_latch = 0;
    tick(3);
    if (d[1:0] == 2'b10) e = d;
  endtask
  task automatic check;
    cmp("word", e, word);
    cmp("fields", e[29:2], fld);
    cmp("div_reset", exp_div(e, shared_pin), dr);
    cmp("pump_hold", exp_hold(e, shared_pin), ph);
  endtask
  initial begin
    void'($urandom(77275));
    tick(10);
    rst = 0;
    tick(1);
    check;
    for (int k = 0; k < 24; k++) begin
      v = $urandom;
      if (k % 4) v[1:0] = 2'b10;
      if (k == 1) v = 32'hFFFF_FFFE;
      if (k == 2) v = 32'h0000_0002;
      if (k == 4) v[1:0] = 2'b11;
      if (k == 8) v[1:0] = 2'b01;
      send(v);
      check;
    end
    rst = 1;
    tick(2);
    rst = 0;
    tick(1);
    e = 32'hDB6D_B4A2;
    check;
    final_report;
  end
  initial begin
    #1_000_000;
    num_errors++;
    final_report;
  end
endmodule
bind pllcw_top pllcw_monitor u_mon (.*);
